/* bench/eau_dec_model.sv */
/*
  Decoder-side partner: holds the address register and stack pointer
  values that accompany each request, and the memory-mode pin.
  Assumes the bench loads new values between requests.
*/
`timescale 1ns/1ns
`default_nettype none
module eau_dec_model (
  // Clock and load strobe.
  input  wire logic        i_core_clk,
  input  wire logic        i_load,
  input  wire logic [47:0] i_vals,
  // Values towards the unit.
  output logic [15:0]      o_a0,
  output logic [15:0]      o_a1,
  output logic [15:0]      o_sp,
  output logic             o_memory_mode_pin
);
  // The pin is strapped low for single-chip operation.
  assign o_memory_mode_pin = 1'b0;
  always_ff @(posedge i_core_clk) begin
    if (i_load) begin
      {o_a0, o_a1, o_sp} <= i_vals;
    end
  end
endmodule : eau_dec_model
`default_nettype wire

/* bench/eau_unit_sva.sv */
/*
  Concurrent checks on the effective-address unit ports.
  Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module eau_unit_sva
  import eau_pkg::*;
#(
  parameter logic [15:0] RAM_LAST  = 16'h0BFF,
  parameter logic [15:0] ROM_FIRST = 16'h4000
) (
  // Clock, reset and request side.
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire eau_req_t    i_req,
  input  wire logic [15:0] i_a0,
  input  wire logic [15:0] i_a1,
  input  wire logic [15:0] i_sp,
  input  wire logic        i_pc_load,
  // Results.
  input  wire eau_ea_t     o_ea,
  input  wire logic [18:0] o_pc,
  input  wire logic        o_single_chip
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic [15:0] ar = i_req.areg_sel ? i_a1 : i_a0;
  wire logic [18:0] op = i_req.operand;
  wire logic        rq = i_req.valid;
  wire logic        xf = (i_req.cls == CL_BYTE_XFER);
  a_ea_latency: assert property (o_ea.valid == $past(rq))
    else $error("result valid does not follow request");
  a_indirect_addr: assert property (rq && i_req.mode == MD_REG_INDIRECT |=>
    o_ea.fault || o_ea.addr == {2'b00, $past(ar)}) else $error("indirect address wrong");
  a_reg_rel_addr: assert property (rq && i_req.mode == MD_REG_REL && i_req.size == SZ_8 |=>
    o_ea.fault || o_ea.addr[15:0] == $past(ar + {{8{op[7]}}, op[7:0]}))
    else $error("register relative address wrong");
  a_stack_rel_addr: assert property (rq && i_req.mode == MD_SP_REL && i_req.size == SZ_4 |=>
    o_ea.fault || o_ea.addr[15:0] == $past(i_sp + {{12{op[3]}}, op[3:0]}))
    else $error("stack relative address wrong");
  a_ram_short: assert property (rq && i_req.mode == MD_RAM_SHORT && xf |=>
    !o_ea.fault && o_ea.addr == {10'h000, $past(op[7:0])}) else $error("short ram address wrong");
  a_io_short: assert property (rq && i_req.mode == MD_IO_SHORT && xf |=>
    !o_ea.fault && o_ea.region == RG_SFR && o_ea.addr == {10'h03F, $past(op[7:0])})
    else $error("short io address wrong");
  a_alu_fault: assert property (rq && i_req.cls == CL_ALU &&
    !(i_req.mode inside {MD_REG_DIRECT, MD_IMMEDIATE}) |=> o_ea.fault)
    else $error("alu memory operand accepted");
  a_imm_value: assert property (rq && i_req.mode == MD_IMMEDIATE && i_req.size == SZ_8 |=>
    !o_ea.mem && o_ea.imm == {8'h00, $past(op[7:0])}) else $error("immediate wrong");
  a_word_next: assert property (o_ea.valid && o_ea.mem && o_ea.word && !o_ea.fault |->
    o_ea.addr_next == o_ea.addr[15:0] + 16'h0001) else $error("word high byte address wrong");
  a_branch_target: assert property (rq && i_req.mode == MD_PC_REL && i_req.size == SZ_4 &&
    i_req.cls == CL_BRANCH && !i_pc_load |=> o_pc == {o_ea.addr, o_ea.half} &&
    o_pc == $past(o_pc + {{15{op[3]}}, op[3:0]})) else $error("branch target wrong");
  a_unmapped_hole: assert property (rq && i_req.mode == MD_ABSOLUTE && i_req.size == SZ_16 &&
    xf && o_single_chip && op[15:0] > RAM_LAST && op[15:0] < 16'h3F00 |=> o_ea.fault)
    else $error("unmapped address not faulted");
  c_reuse: cover property (rq && i_req.mode == MD_REUSE_LAST);
  c_branch: cover property (rq && i_req.mode == MD_PC_REL);
  c_fault: cover property (o_ea.valid && o_ea.fault);
endmodule : eau_unit_sva
bind eau_unit eau_unit_sva #(.RAM_LAST(RAM_LAST), .ROM_FIRST(ROM_FIRST)) eau_unit_sva_i (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_a0(i_a0), .i_a1(i_a1),
  .i_sp(i_sp), .i_pc_load(i_pc_load), .o_ea(o_ea), .o_pc(o_pc), .o_single_chip(o_single_chip));
`default_nettype wire

/* bench/eau_unit_test.sv */
/*
  Self-checking bench for the effective-address unit.
  Assumes the checker is bound in and the decoder model is compiled.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module eau_unit_test;
  import eau_pkg::*;
  logic clk, rst, ld, pcl, awv, wv, br, arv, rr;
  logic [47:0] vals;
  logic [18:0] pcv;
  logic [4:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] rs;
  eau_req_t rqs;
  eau_ea_t o_ea;
  logic [15:0] a0, a1, sp;
  logic [18:0] o_pc;
  logic pin, sc, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors, n_checks, cyc;
  eau_mode_t xm [7] = '{MD_REG_INDIRECT, MD_REG_REL, MD_SP_REL, MD_ABSOLUTE,
                        MD_RAM_SHORT, MD_IO_SHORT, MD_REUSE_LAST};
  eau_dec_model eau_dec_model_i (.i_core_clk(clk), .i_load(ld), .i_vals(vals), .o_a0(a0),
    .o_a1(a1), .o_sp(sp), .o_memory_mode_pin(pin));
  eau_unit eau_unit_i (.i_core_clk(clk), .i_sys_rst(rst), .i_req(rqs), .i_a0(a0), .i_a1(a1),
    .i_sp(sp), .i_pc_load(pcl), .i_pc_value(pcv), .i_memory_mode_pin(pin), .o_ea(o_ea),
    .o_pc(o_pc), .o_single_chip(sc), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp),
    .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr));
  always #25 clk = ~clk;
  // A hang is cut short at cycle 5000, well beyond the roughly 110 cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // One request; the result is looked at in the cycle it stands.
  task automatic rq(eau_mode_t m, eau_size_t s, eau_class_t c, logic sel, logic [18:0] op);
    @(posedge clk) rqs <= '{1'b1, m, s, c, sel, op};
    @(posedge clk) rqs.valid <= 1'b0;
    #1;
  endtask : rq
  task automatic axw(logic [4:0] a, logic [31:0] d, output logic [1:0] r);
    logic pa, pw, pb, ha, hw, hb;
    pa = 1; pw = 1; pb = 1;
    @(posedge clk) begin awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1; end
    while (pa || pw || pb) begin
      #1; ha = pa & awr; hw = pw & wr; hb = pb & bv;
      if (hb) r = bresp;
      @(posedge clk);
      if (ha) begin awv <= 0; pa = 0; end
      if (hw) begin wv <= 0; pw = 0; end
      if (hb) begin br <= 0; pb = 0; end
    end
  endtask : axw
  task automatic axr(logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, pr, ha, hr;
    pa = 1; pr = 1;
    @(posedge clk) begin ara <= a; arv <= 1; rr <= 1; end
    while (pa || pr) begin
      #1; ha = pa & arr; hr = pr & rv;
      if (hr) begin d = rdata; r = rresp; end
      @(posedge clk);
      if (ha) begin arv <= 0; pa = 0; end
      if (hr) begin rr <= 0; pr = 0; end
    end
  endtask : axr
  initial begin
    clk = 0; rst = 1; ld = 0; pcl = 0; pcv = '0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
    awa = '0; ara = '0; wd = '0; rqs = '0; vals = {16'h0123, 16'h0100, 16'h0200};
    n_errors = 0; n_checks = 0; cyc = 0;
    @(posedge clk) ld <= 1;
    repeat (5) @(posedge clk);
    rst <= 0; ld <= 0;
    repeat (4) @(posedge clk);
    axr(5'h00, rd, rs); `CHK(rd, 32'h00000000)
    axr(5'h04, rd, rs); `CHK(rd, 32'h00000000)
    axr(5'h08, rd, rs); `CHK(rd, 32'h00000001)
    axr(5'h10, rd, rs); `CHK(rd, 32'h00000000)
    axr(5'h14, rd, rs); `CHK({rs, rd}, 34'h200000000)
    axw(5'h14, 32'h1, rs); `CHK(rs, 2'h2)
    rq(MD_REG_INDIRECT, SZ_16, CL_BYTE_XFER, 0, 0); `CHK(o_ea.addr, 18'h00123)
    `CHK(o_ea.region, RG_RAM)
    rq(MD_REG_REL, SZ_8, CL_BYTE_XFER, 1, 19'hFF); `CHK(o_ea.addr, 18'h000FF)
    rq(MD_REG_REL, SZ_16, CL_WORD_XFER, 1, 19'h1); `CHK(o_ea.addr_next, 16'h0102)
    `CHK({o_ea.fault, o_ea.addr}, 19'h00101)
    rq(MD_SP_REL, SZ_4, CL_BYTE_XFER, 0, 19'h8); `CHK(o_ea.addr, 18'h001F8)
    rq(MD_ABSOLUTE, SZ_16, CL_BYTE_XFER, 0, 19'h4000); `CHK(o_ea.region, RG_ROM)
    rq(MD_ABSOLUTE, SZ_18, CL_BYTE_XFER, 0, 19'h4000); `CHK(o_ea.fault, 1'b1)
    rq(MD_ABSOLUTE, SZ_16, CL_BYTE_XFER, 0, 19'h1000); `CHK(o_ea.fault, 1'b1)
    rq(MD_RAM_SHORT, SZ_8, CL_BYTE_XFER, 0, 19'hFF); `CHK(o_ea.addr, 18'h000FF)
    rq(MD_IO_SHORT, SZ_8, CL_BYTE_XFER, 0, 19'h12); `CHK(o_ea.addr, 18'h03F12)
    `CHK(o_ea.region, RG_SFR)
    rq(MD_REUSE_LAST, SZ_8, CL_WORD_XFER, 0, 0); `CHK(o_ea.addr, 18'h03F12)
    rq(MD_REUSE_LAST, SZ_8, CL_ALU, 0, 0); `CHK(o_ea.fault, 1'b1)
    rq(MD_REG_INDIRECT, SZ_8, CL_ALU, 0, 0); `CHK(o_ea.fault, 1'b1)
    rq(MD_IMMEDIATE, SZ_8, CL_ALU, 0, 19'hA5); `CHK({o_ea.mem, o_ea.imm}, 17'h000A5)
    rq(MD_REG_DIRECT, SZ_8, CL_ALU, 0, 0); `CHK({o_ea.mem, o_ea.fault}, 2'b00)
    axr(5'h08, rd, rs); `CHK(rd[3:2], 2'b11)
    axw(5'h08, 32'h4, rs); axr(5'h08, rd, rs); `CHK(rd[2], 1'b0)
    foreach (xm[i]) begin
      rq(xm[i], SZ_8, CL_BYTE_XFER, 0, 0); `CHK({o_ea.mem, o_ea.fault}, 2'b10)
    end
    axr(5'h0C, rd, rs); `CHK(rd, 32'h00003F00)
    @(posedge clk) begin pcl <= 1; pcv <= 19'h08000; end
    @(posedge clk) pcl <= 0;
    rq(MD_PC_REL, SZ_4, CL_BRANCH, 0, 19'h3); `CHK({o_ea.addr, o_ea.half}, 19'h08003)
    `CHK(o_pc, 19'h08003)
    rq(MD_PC_REL, SZ_4, CL_BRANCH, 0, 19'hE); `CHK(o_pc, 19'h08001)
    rq(MD_ABSOLUTE, SZ_18, CL_BRANCH, 0, 19'h12345); `CHK(o_pc, 19'h12345)
    rq(MD_PC_REL, SZ_4, CL_BYTE_XFER, 0, 19'h3); `CHK(o_ea.fault, 1'b1)
    axw(5'h00, 32'h1, rs); repeat (3) @(posedge clk); `CHK(sc, 1'b0)
    rq(MD_ABSOLUTE, SZ_16, CL_BYTE_XFER, 0, 19'h1000); `CHK(o_ea.fault, 1'b0)
    axw(5'h00, 32'h0, rs); repeat (3) @(posedge clk); `CHK(sc, 1'b1)
    final_report();
  end
endmodule : eau_unit_test
`default_nettype wire

/* src/eau_map.svh */
/*
  Address map, register offsets, field positions and reset values of the
  effective-address unit. Assumes inclusion by bare name from a package
  or module; it holds definitions only.
*/
`ifndef EAU_MAP_SVH
`define EAU_MAP_SVH

// ****************************************************************
// Internal memory map.
// ****************************************************************
`define EAU_RAM_FIRST    16'h0000
`define EAU_RAM_LAST     16'h0BFF
`define EAU_SFR_BASE     16'h3F00
`define EAU_SFR_LAST     16'h3FFF
`define EAU_ROM_FIRST    16'h4000
`define EAU_ROM_LAST     16'hFFFF

// ****************************************************************
// Register offsets on the AXI4-Lite bus.
// ****************************************************************
`define EAU_OFS_MEMCTL   5'h00
`define EAU_OFS_AREACTL  5'h04
`define EAU_OFS_STATUS   5'h08
`define EAU_OFS_LASTADDR 5'h0C
`define EAU_OFS_PC       5'h10

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define EAU_BIT_EXTMEM   0
`define EAU_BIT_CSEXT    0
`define EAU_BIT_SINGLE   0
`define EAU_BIT_PIN      1
`define EAU_BIT_FAULT    2
`define EAU_BIT_LASTVLD  3
`define EAU_PC_RESET     19'h00000
`define EAU_RESP_OKAY    2'h0
`define EAU_RESP_SLVERR  2'h2

`endif

/* src/eau_pkg.sv */
/*
  Types shared by the effective-address unit: modes, operand sizes,
  instruction classes, memory regions and the request and result carriers.
  Assumes the map header is on the include path.
*/
package eau_pkg;

  // ****************************************************************
  // Enumerations.
  // ****************************************************************
  typedef enum logic [3:0] {
    MD_REG_DIRECT, MD_IMMEDIATE, MD_REG_INDIRECT, MD_REG_REL, MD_PC_REL,
    MD_SP_REL, MD_ABSOLUTE, MD_RAM_SHORT, MD_IO_SHORT, MD_REUSE_LAST
  } eau_mode_t;

  typedef enum logic [2:0] {
    SZ_4, SZ_7, SZ_8, SZ_11, SZ_12, SZ_16, SZ_18
  } eau_size_t;

  typedef enum logic [2:0] {
    CL_BYTE_XFER, CL_WORD_XFER, CL_ALU, CL_BRANCH, CL_OTHER
  } eau_class_t;

  typedef enum logic [1:0] {
    RG_RAM, RG_SFR, RG_ROM, RG_NONE
  } eau_region_t;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    eau_mode_t   mode;
    eau_size_t   size;
    eau_class_t  cls;
    logic        areg_sel;
    logic [18:0] operand;
  } eau_req_t;

  typedef struct packed {
    logic        valid;
    logic        mem;
    logic        fault;
    logic        word;
    logic        half;
    eau_region_t region;
    logic [17:0] addr;
    logic [15:0] addr_next;
    logic [15:0] imm;
  } eau_ea_t;

endpackage : eau_pkg

/* src/eau_unit.sv */
/*
  Effective-address unit of an 8-bit CPU core with its single-chip memory
  decode and a small AXI4-Lite register set. Assumes the decoder presents
  one request per cycle on the core clock and holds the address register,
  stack pointer values valid in that cycle.
*/
// Our own choices: register access over AXI4-Lite and the placing of the registers.
// Summary of operation
// - Indirect mode uses full address register.
// - Register-relative adds 8/16-bit displacement.
// - Branches add displacement to PC, 18+H.
// - Stack-relative adds 4/8/16-bit displacement to SP.
// - Absolute takes 8/12/16-bit; 18-bit branches only.
// - RAM short reaches lowest 256 bytes.
// - I/O short adds operand to SFR base.
// - Handy reuses last address, transfers only.
// - PC displacements count in half-byte units.
// - ALU operands: register direct, immediate only.
// - Seven modes serve memory transfers.
// - Immediate operand taken without memory access.
// - Register direct generates no memory address.
// - Single-chip decodes internal RAM, SFR area and ROM only.
// - SFR area spans 3F00 through 3FFF.
// - Nineteen-bit PC, LSB selects half byte.
`timescale 1ns/1ns
`default_nettype none
`include "eau_map.svh"

module eau_unit
  import eau_pkg::*;
#(
  parameter logic [15:0] RAM_LAST  = `EAU_RAM_LAST,
  parameter logic [15:0] ROM_FIRST = `EAU_ROM_FIRST
) (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // Decoder request and register values.
  input  wire eau_req_t    i_req,
  input  wire logic [15:0] i_a0,
  input  wire logic [15:0] i_a1,
  input  wire logic [15:0] i_sp,
  input  wire logic        i_pc_load,
  input  wire logic [18:0] i_pc_value,
  // Device pin.
  input  wire logic        i_memory_mode_pin,
  // Result towards the memory bus.
  output eau_ea_t          o_ea,
  output logic [18:0]      o_pc,
  output logic             o_single_chip,
  // AXI4-Lite slave.
  input  wire logic [4:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [4:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  if (RAM_LAST >= `EAU_SFR_BASE || ROM_FIRST <= `EAU_SFR_LAST) begin : g_bad_map
    $error("RAM or ROM bounds overlap the special function area.");
  end

  // ****************************************************************
  // Functions.
  // ****************************************************************
  function automatic logic [15:0] sext(input logic [18:0] op, input eau_size_t sz);
    unique case (sz)
      SZ_4:    sext = {{12{op[3]}}, op[3:0]};
      SZ_7:    sext = {{9{op[6]}}, op[6:0]};
      SZ_8:    sext = {{8{op[7]}}, op[7:0]};
      SZ_11:   sext = {{5{op[10]}}, op[10:0]};
      SZ_12:   sext = {{4{op[11]}}, op[11:0]};
      default: sext = op[15:0];
    endcase
  endfunction : sext

  function automatic logic [15:0] zext(input logic [18:0] op, input eau_size_t sz);
    unique case (sz)
      SZ_4:    zext = {12'h000, op[3:0]};
      SZ_8:    zext = {8'h00, op[7:0]};
      SZ_12:   zext = {4'h0, op[11:0]};
      default: zext = op[15:0];
    endcase
  endfunction : zext

  function automatic eau_region_t region_of(input logic [15:0] a);
    if (a <= RAM_LAST) begin
      region_of = RG_RAM;
    end else if (a >= `EAU_SFR_BASE && a <= `EAU_SFR_LAST) begin
      region_of = RG_SFR;
    end else if (a >= ROM_FIRST) begin
      region_of = RG_ROM;
    end else begin
      region_of = RG_NONE;
    end
  endfunction : region_of

  // ****************************************************************
  // State.
  // ****************************************************************
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic        ext_flag_reg;
  logic        cs_ext_reg;
  logic        fault_seen_reg;
  logic [15:0] last_addr_reg;
  logic        last_vld_reg;
  logic [18:0] pc_reg;
  eau_ea_t     ea_reg;
  logic        single_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [4:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;

  // ****************************************************************
  // Address calculation.
  // ****************************************************************
  wire eau_mode_t  mode     = i_req.mode;
  wire eau_size_t  size     = i_req.size;
  wire eau_class_t cls      = i_req.cls;
  wire [15:0]      areg     = i_req.areg_sel ? i_a1 : i_a0;
  wire [15:0]      disp     = sext(i_req.operand, size);
  wire [15:0]      a_ind    = areg;
  wire [15:0]      a_rel    = areg + disp;
  wire [15:0]      a_sp     = i_sp + disp;
  wire [15:0]      a_abs    = zext(i_req.operand, size);
  wire [15:0]      a_ram    = {8'h00, i_req.operand[7:0]};
  wire [15:0]      a_io     = `EAU_SFR_BASE + {8'h00, i_req.operand[7:0]};
  // Displacements count half bytes, so the PC sum carries the H bit at bit 0.
  wire [18:0]      pc_disp  = {{3{disp[15]}}, disp};
  wire [18:0]      pc_tgt   = pc_reg + pc_disp;
  wire             abs18    = (mode == MD_ABSOLUTE) && (size == SZ_18);
  wire [18:0]      br_tgt   = abs18 ? i_req.operand : pc_tgt;

  wire [15:0] data_addr =
      (mode == MD_REG_INDIRECT) ? a_ind :
      (mode == MD_REG_REL)      ? a_rel :
      (mode == MD_SP_REL)       ? a_sp  :
      (mode == MD_ABSOLUTE)     ? a_abs :
      (mode == MD_RAM_SHORT)    ? a_ram :
      (mode == MD_IO_SHORT)     ? a_io  : last_addr_reg;

  // ****************************************************************
  // Legality and decode.
  // ****************************************************************
  wire is_xfer   = (cls == CL_BYTE_XFER) || (cls == CL_WORD_XFER);
  wire is_branch = (mode == MD_PC_REL) || abs18;
  wire is_mem    = !is_branch && (mode inside {MD_REG_INDIRECT, MD_REG_REL, MD_SP_REL,
                   MD_ABSOLUTE, MD_RAM_SHORT, MD_IO_SHORT, MD_REUSE_LAST});
  wire size_ok   =
      (mode == MD_REG_REL)   ? (size inside {SZ_8, SZ_16}) :
      (mode == MD_PC_REL)    ? (size inside {SZ_4, SZ_7, SZ_11, SZ_12, SZ_16}) :
      (mode == MD_SP_REL)    ? (size inside {SZ_4, SZ_8, SZ_16}) :
      (mode == MD_ABSOLUTE)  ? (size inside {SZ_8, SZ_12, SZ_16, SZ_18}) :
      (mode == MD_IMMEDIATE) ? (size inside {SZ_4, SZ_8, SZ_16}) : 1'b1;
  wire bad_alu   = (cls == CL_ALU) && !(mode inside {MD_REG_DIRECT, MD_IMMEDIATE});
  wire bad_br    = is_branch && (cls != CL_BRANCH);
  wire bad_reuse = (mode == MD_REUSE_LAST) && (!is_xfer || !last_vld_reg);
  wire word      = cls == CL_WORD_XFER;
  // The second byte of a word may sit at an odd address; no alignment check.
  wire [15:0] addr_hi = data_addr + 16'h0001;
  wire single    = !pin_sync_reg && !ext_flag_reg && !cs_ext_reg;
  wire eau_region_t rg_lo = region_of(data_addr);
  wire eau_region_t rg_hi = region_of(addr_hi);
  wire unmapped  = is_mem && single && (rg_lo == RG_NONE || (word && rg_hi == RG_NONE));
  wire fault     = !size_ok || bad_alu || bad_br || bad_reuse || unmapped;
  wire take_mem  = i_req.valid && is_mem && !fault;
  wire take_br   = i_req.valid && is_branch && !fault;

  eau_ea_t ea_next;
  always_comb begin
    ea_next           = '0;
    ea_next.valid     = i_req.valid;
    ea_next.mem       = is_mem;
    ea_next.fault     = fault;
    ea_next.word      = word;
    ea_next.region    = is_mem ? rg_lo : RG_NONE;
    ea_next.addr      = is_branch ? br_tgt[18:1] : (is_mem ? {2'b00, data_addr} : 18'h00000);
    ea_next.half      = is_branch && br_tgt[0];
    ea_next.addr_next = (is_mem && word) ? addr_hi : 16'h0000;
    ea_next.imm       = (mode == MD_IMMEDIATE) ? zext(i_req.operand, size) : 16'h0000;
  end

  // ****************************************************************
  // AXI4-Lite decode.
  // ****************************************************************
  wire aw_take  = i_awvalid && o_awready;
  wire w_take   = i_wvalid && o_wready;
  wire wr_go    = aw_hold_reg && w_hold_reg && !o_bvalid;
  wire ar_take  = i_arvalid && o_arready;
  wire wr_en    = wr_go && wstrb0_reg;
  wire wr_mem   = wr_en && (awaddr_reg == `EAU_OFS_MEMCTL);
  wire wr_area  = wr_en && (awaddr_reg == `EAU_OFS_AREACTL);
  wire wr_stat  = wr_en && (awaddr_reg == `EAU_OFS_STATUS);
  wire wr_known = awaddr_reg inside {`EAU_OFS_MEMCTL, `EAU_OFS_AREACTL, `EAU_OFS_STATUS,
                  `EAU_OFS_LASTADDR, `EAU_OFS_PC};
  wire rd_known = i_araddr inside {`EAU_OFS_MEMCTL, `EAU_OFS_AREACTL, `EAU_OFS_STATUS,
                  `EAU_OFS_LASTADDR, `EAU_OFS_PC};
  wire aw_hold_next = wr_go ? 1'b0 : (aw_hold_reg || aw_take);
  wire w_hold_next  = wr_go ? 1'b0 : (w_hold_reg || w_take);
  wire bvalid_next  = wr_go || (o_bvalid && !i_bready);
  wire rvalid_next  = ar_take || (o_rvalid && !i_rready);
  // A fault in the same cycle as a clear keeps the flag set.
  wire clr_fault    = wr_stat && wdata_reg[`EAU_BIT_FAULT];
  wire fault_next   = (i_req.valid && fault) || (fault_seen_reg && !clr_fault);
  wire [31:0] status_word = {28'h0000000, last_vld_reg, fault_seen_reg,
                             pin_sync_reg, single_reg};
  wire [31:0] rd_word =
      (i_araddr == `EAU_OFS_MEMCTL)   ? {31'h00000000, ext_flag_reg} :
      (i_araddr == `EAU_OFS_AREACTL)  ? {31'h00000000, cs_ext_reg}   :
      (i_araddr == `EAU_OFS_STATUS)   ? status_word                  :
      (i_araddr == `EAU_OFS_LASTADDR) ? {16'h0000, last_addr_reg}    :
      (i_araddr == `EAU_OFS_PC)       ? {13'h0000, pc_reg}           : 32'h00000000;

  // ****************************************************************
  // Pin synchroniser and core state.
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta_reg   <= 1'b0;
      pin_sync_reg   <= 1'b0;
      ea_reg         <= '0;
      single_reg     <= 1'b0;
      last_addr_reg  <= 16'h0000;
      last_vld_reg   <= 1'b0;
      pc_reg         <= `EAU_PC_RESET;
      fault_seen_reg <= 1'b0;
    end else begin
      pin_meta_reg   <= i_memory_mode_pin;
      pin_sync_reg   <= pin_meta_reg;
      ea_reg         <= ea_next;
      single_reg     <= single;
      fault_seen_reg <= fault_next;
      if (take_mem) begin
        last_addr_reg <= data_addr;
        last_vld_reg  <= 1'b1;
      end
      if (i_pc_load) begin
        pc_reg <= i_pc_value;
      end else if (take_br) begin
        pc_reg <= br_tgt;
      end
    end
  end

  // ****************************************************************
  // Bus slave state.
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 5'h00;
      wdata_reg    <= 32'h00000000;
      wstrb0_reg   <= 1'b0;
      ext_flag_reg <= 1'b0;
      cs_ext_reg   <= 1'b0;
      o_awready    <= 1'b0;
      o_wready     <= 1'b0;
      o_bvalid     <= 1'b0;
      o_bresp      <= `EAU_RESP_OKAY;
      o_arready    <= 1'b0;
      o_rvalid     <= 1'b0;
      o_rdata      <= 32'h00000000;
      o_rresp      <= `EAU_RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      o_awready   <= !aw_hold_next && !bvalid_next;
      o_wready    <= !w_hold_next && !bvalid_next;
      o_bvalid    <= bvalid_next;
      o_rvalid    <= rvalid_next;
      o_arready   <= !rvalid_next;
      if (aw_take) begin
        awaddr_reg <= i_awaddr;
      end
      if (w_take) begin
        wdata_reg  <= i_wdata;
        wstrb0_reg <= i_wstrb[0];
      end
      if (wr_go) begin
        o_bresp <= wr_known ? `EAU_RESP_OKAY : `EAU_RESP_SLVERR;
      end
      if (wr_mem) begin
        ext_flag_reg <= wdata_reg[`EAU_BIT_EXTMEM];
      end
      if (wr_area) begin
        cs_ext_reg <= wdata_reg[`EAU_BIT_CSEXT];
      end
      if (ar_take) begin
        o_rdata <= rd_word;
        o_rresp <= rd_known ? `EAU_RESP_OKAY : `EAU_RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign o_ea          = ea_reg;
  assign o_pc          = pc_reg;
  assign o_single_chip = single_reg;

endmodule : eau_unit
`default_nettype wire
